// File: rtl/isr_pkg.sv
package isr_pkg;

  // ==========================================================
  // register widths and reset values
  localparam int          OP_W        = 16;
  localparam int          QS_W        = 16;
  localparam int          STB_W       = 8;
  localparam int          RESP_W      = 16;
  localparam int          ESR_W       = 8;
  localparam logic [15:0] PTR_RST     = 16'hffff;
  localparam logic [15:0] NTR_RST     = 16'h0000;
  localparam logic [15:0] ENA_RST     = 16'h0000;
  localparam logic [7:0]  SRE_RST     = 8'h00;

  // ==========================================================
  // operation condition bit positions
  localparam int          OP_MOTOR_BIT   = 1;
  localparam int          OP_RANGING_BIT = 2;
  localparam int          OP_MEASURE_BIT = 4;
  localparam int          OP_PROCESS_BIT = 9;
  localparam int          OP_HCOPY_BIT   = 10;
  localparam int          OP_AVERAGE_BIT = 11;
  localparam logic [15:0] OP_USED_MASK   = 16'h0e16;

  // ==========================================================
  // signal-quality bit positions
  localparam int          QS_POWER_BIT   = 3;
  localparam int          QS_MAXSIG_BIT  = 9;
  localparam int          QS_DRIFT_BIT   = 10;
  localparam int          QS_DELTA_BIT   = 11;
  localparam int          QS_CMDWARN_BIT = 14;
  localparam logic [15:0] QS_USED_MASK   = 16'h4e08;

  // ==========================================================
  // status byte bit positions
  localparam int          STB_QUES_BIT = 3;
  localparam int          STB_MAV_BIT  = 4;
  localparam int          STB_ESB_BIT  = 5;
  localparam int          STB_RQS_BIT  = 6;
  localparam int          STB_OPER_BIT = 7;

  // ==========================================================
  // register group and item selection
  localparam logic        GRP_OP = 1'b0;
  localparam logic        GRP_QS = 1'b1;

  typedef enum logic [2:0] {
    ITEM_COND   = 3'h0,
    ITEM_EVENT  = 3'h1,
    ITEM_ENABLE = 3'h2,
    ITEM_PTR    = 3'h3,
    ITEM_NTR    = 3'h4
  } isr_item_e;

endpackage

// File: rtl/isr_grp_if.sv
`timescale 1ns/100ps
// signals between the top and one event group
interface isr_grp_if #(parameter int W = 16);
  logic [W-1:0] cond;
  logic [W-1:0] wr_data;
  logic         wr_enable;
  logic         wr_ptr;
  logic         wr_ntr;
  logic         clr_event;
  logic [W-1:0] event_bits;
  logic [W-1:0] enable;
  logic [W-1:0] ptr;
  logic [W-1:0] ntr;
  logic         summary;

  modport grp (input cond, wr_data, wr_enable, wr_ptr, wr_ntr, clr_event,
               output event_bits, enable, ptr, ntr, summary);
  modport ctrl (output cond, wr_data, wr_enable, wr_ptr, wr_ntr, clr_event,
                input event_bits, enable, ptr, ntr, summary);
endinterface

// File: rtl/isr_event_group.sv
`timescale 1ns/100ps
module isr_event_group
  import isr_pkg::*;
#(
  parameter int         W         = 16,
  parameter logic [W-1:0] USED_MASK = '1
)(
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  isr_grp_if.grp    grp
);

  logic [W-1:0] cond_prev_reg;
  logic [W-1:0] event_reg;
  logic [W-1:0] enable_reg;
  logic [W-1:0] ptr_reg;
  logic [W-1:0] ntr_reg;
  wire  [W-1:0] cond_used;
  wire  [W-1:0] rise_set;
  wire  [W-1:0] fall_set;
  wire  [W-1:0] set_vec;
  wire  [W-1:0] event_next;

  // ==========================================================
  // transition filters; unused positions never see a condition
  assign cond_used  = grp.cond & USED_MASK;
  assign rise_set   = cond_used & ~cond_prev_reg & ptr_reg;
  assign fall_set   = ~cond_used & cond_prev_reg & ntr_reg;
  assign set_vec    = rise_set | fall_set;
  // a new event beats a clear in the same cycle
  assign event_next = (event_reg & ~{W{grp.clr_event}}) | set_vec;

  // ==========================================================
  // state and masks; the enable mask drops unused bits so they cannot summarise
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cond_prev_reg <= '0;
      event_reg     <= '0;
      enable_reg    <= W'(ENA_RST);
      ptr_reg       <= W'(PTR_RST);
      ntr_reg       <= W'(NTR_RST);
    end else begin
      cond_prev_reg <= cond_used;
      event_reg     <= event_next;
      if (grp.wr_enable) begin
        enable_reg <= grp.wr_data & USED_MASK;
      end
      if (grp.wr_ptr) begin
        ptr_reg <= grp.wr_data;
      end
      if (grp.wr_ntr) begin
        ntr_reg <= grp.wr_data;
      end
    end
  end

  // ==========================================================
  // outputs; disabled bits still latch but do not summarise
  assign grp.event_bits = event_reg;
  assign grp.enable     = enable_reg;
  assign grp.ptr        = ptr_reg;
  assign grp.ntr        = ntr_reg;
  assign grp.summary    = |(event_reg & enable_reg);

  // ==========================================================
  // checks
  a_rise_latches: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (|rise_set) |=> ((event_reg & $past(rise_set)) == $past(rise_set)))
    else $error("rising transition not latched");
  a_fall_latches: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (|fall_set) |=> ((event_reg & $past(fall_set)) == $past(fall_set)))
    else $error("falling transition not latched");
  a_unused_quiet: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ((event_reg | enable_reg) & ~USED_MASK) == '0)
    else $error("unused position reports a value");
  a_summary_gated: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (grp.summary && !$past(grp.summary)) |-> (|(event_reg & enable_reg)) ##0
    (|(($past(event_reg) & ~$past(enable_reg)) | event_reg)))
    else $error("summary rose without an enabled event");

endmodule

// File: rtl/isr_status_top.sv
`timescale 1ns/100ps
// Summary of operation
// - status byte bits follow their summary sources, set while present, clear when absent
// - each summary bit is the OR of its source register bits masked by their enable register
// - poll and status query return the weighted sum of currently set bits
// - serial poll reports bit 6 as service request, then clears it
// - status query reports bit 6 as master summary, touching nothing
// - positive filter latches an event on a false-to-true condition change
// - negative filter latches an event on a true-to-false condition change
// - operation bit 1 shows waiting for the wavelength motor to settle
// - operation bit 2 shows gain ranging in progress
// - operation bit 4 shows a measurement in progress
// - operation bit 9 shows acquired data being processed
// - operation bit 10 shows printing through the parallel port
// - operation bit 11 shows noise averaging for signal-to-noise
// - operation positions 0, 3, 5-8, 12-15 never report a condition
// - signal-quality bit 3 shows excessive input power
// - signal-quality bit 9 shows maximum signal count reached
// - signal-quality bit 10 shows drift reference count mismatch
// - signal-quality bit 11 shows missing delta reference
// - signal-quality bit 14 shows unexpected extra measurement parameters
// - status bit 5 is the OR of enabled standard event bits
// - status bit 4 is set while the output queue holds bytes
// - operation and quality events summarise only when enabled; disabled ones still latch
module isr_status_top
  import isr_pkg::*;
#(
  parameter int OPW = OP_W,
  parameter int QSW = QS_W
)(
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  input  wire logic              motor_position_wait_in,
  input  wire logic              ranging_in,
  input  wire logic              measuring_in,
  input  wire logic              processing_in,
  input  wire logic              hardcopy_in,
  input  wire logic              averaging_in,
  input  wire logic              power_high_in,
  input  wire logic              max_signals_in,
  input  wire logic              drift_ref_mismatch_in,
  input  wire logic              delta_ref_missing_in,
  input  wire logic              cmd_warning_in,
  input  wire logic [ESR_W-1:0]  std_event_in,
  input  wire logic [ESR_W-1:0]  std_event_enable_in,
  input  wire logic              msg_avail_in,
  input  wire logic              serial_poll_in,
  input  wire logic              stb_query_in,
  input  wire logic              sre_wr_in,
  input  wire logic [STB_W-1:0]  sre_data_in,
  input  wire logic              cls_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  input  wire logic              reg_grp_in,
  input  wire isr_item_e         reg_item_in,
  input  wire logic [RESP_W-1:0] reg_wdata_in,
  output logic                   resp_valid_out,
  output logic      [RESP_W-1:0] resp_data_out,
  output logic                   srq_out
);

  isr_grp_if #(.W(OPW)) op_if ();
  isr_grp_if #(.W(QSW)) qs_if ();

  logic [STB_W-1:0]  sre_reg;
  logic              rqs_reg;
  logic              mss_prev_reg;
  logic              resp_valid_reg;
  logic [RESP_W-1:0] resp_data_reg;
  wire               esb_wire;
  wire  [STB_W-1:0]  stb_base;
  wire               mss_wire;
  wire               mss_rise;
  wire               rqs_next;
  wire               rd_take;
  wire               wr_op;
  wire               wr_qs;
  wire  [RESP_W-1:0] rd_value;
  wire  [STB_W-1:0]  poll_byte;
  wire  [STB_W-1:0]  query_byte;
  wire  [RESP_W-1:0] resp_next;

  // picks one item of a group for a register read
  function automatic logic [RESP_W-1:0] item_value(
    input isr_item_e         item,
    input logic [RESP_W-1:0] cond,
    input logic [RESP_W-1:0] evt,
    input logic [RESP_W-1:0] ena,
    input logic [RESP_W-1:0] ptr,
    input logic [RESP_W-1:0] ntr
  );
    logic [RESP_W-1:0] v;
    v = '0;
    case (item)
      ITEM_COND:   v = cond;
      ITEM_EVENT:  v = evt;
      ITEM_ENABLE: v = ena;
      ITEM_PTR:    v = ptr;
      ITEM_NTR:    v = ntr;
      default:     v = '0;
    endcase
    return v;
  endfunction

  // ==========================================================
  // operation conditions placed at their fixed positions
  assign op_if.cond = (OPW'(motor_position_wait_in) << OP_MOTOR_BIT)
                    | (OPW'(ranging_in)             << OP_RANGING_BIT)
                    | (OPW'(measuring_in)           << OP_MEASURE_BIT)
                    | (OPW'(processing_in)          << OP_PROCESS_BIT)
                    | (OPW'(hardcopy_in)            << OP_HCOPY_BIT)
                    | (OPW'(averaging_in)           << OP_AVERAGE_BIT);

  // signal-quality conditions placed at their fixed positions
  assign qs_if.cond = (QSW'(power_high_in)         << QS_POWER_BIT)
                    | (QSW'(max_signals_in)        << QS_MAXSIG_BIT)
                    | (QSW'(drift_ref_mismatch_in) << QS_DRIFT_BIT)
                    | (QSW'(delta_ref_missing_in)  << QS_DELTA_BIT)
                    | (QSW'(cmd_warning_in)        << QS_CMDWARN_BIT);

  // ==========================================================
  // register writes; one group and item per strobe
  assign wr_op             = reg_wr_in && (reg_grp_in == GRP_OP);
  assign wr_qs             = reg_wr_in && (reg_grp_in == GRP_QS);
  assign op_if.wr_data     = OPW'(reg_wdata_in);
  assign qs_if.wr_data     = QSW'(reg_wdata_in);
  assign op_if.wr_enable   = wr_op && (reg_item_in == ITEM_ENABLE);
  assign op_if.wr_ptr      = wr_op && (reg_item_in == ITEM_PTR);
  assign op_if.wr_ntr      = wr_op && (reg_item_in == ITEM_NTR);
  assign qs_if.wr_enable   = wr_qs && (reg_item_in == ITEM_ENABLE);
  assign qs_if.wr_ptr      = wr_qs && (reg_item_in == ITEM_PTR);
  assign qs_if.wr_ntr      = wr_qs && (reg_item_in == ITEM_NTR);

  // reads lose to a poll or query in the same cycle
  assign rd_take = reg_rd_in && !serial_poll_in && !stb_query_in;
  // reading an event register empties it, as does a clear-status
  assign op_if.clr_event = cls_in || (rd_take && (reg_grp_in == GRP_OP)
                                      && (reg_item_in == ITEM_EVENT));
  assign qs_if.clr_event = cls_in || (rd_take && (reg_grp_in == GRP_QS)
                                      && (reg_item_in == ITEM_EVENT));

  isr_event_group #(.W(OPW), .USED_MASK(OPW'(OP_USED_MASK))) u_op_group (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .grp      (op_if.grp)
  );

  isr_event_group #(.W(QSW), .USED_MASK(QSW'(QS_USED_MASK))) u_qs_group (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .grp      (qs_if.grp)
  );

  assign rd_value = (reg_grp_in == GRP_QS)
    ? item_value(reg_item_in, RESP_W'(qs_if.cond & QS_USED_MASK),
                 RESP_W'(qs_if.event_bits), RESP_W'(qs_if.enable),
                 RESP_W'(qs_if.ptr), RESP_W'(qs_if.ntr))
    : item_value(reg_item_in, RESP_W'(op_if.cond & OP_USED_MASK),
                 RESP_W'(op_if.event_bits), RESP_W'(op_if.enable),
                 RESP_W'(op_if.ptr), RESP_W'(op_if.ntr));

  // ==========================================================
  // status byte: every bit is live, nothing is stored but service request
  assign esb_wire = |(std_event_in & std_event_enable_in);
  assign stb_base = (STB_W'(qs_if.summary) << STB_QUES_BIT)
                  | (STB_W'(msg_avail_in)  << STB_MAV_BIT)
                  | (STB_W'(esb_wire)      << STB_ESB_BIT)
                  | (STB_W'(op_if.summary) << STB_OPER_BIT);
  // bit 6 of the enable mask is ignored so summary cannot feed itself
  assign mss_wire = |(stb_base & sre_reg & ~(STB_W'(1) << STB_RQS_BIT));
  assign mss_rise = mss_wire && !mss_prev_reg;
  // a new request wins over a poll in the same cycle
  assign rqs_next = mss_rise || (rqs_reg && !serial_poll_in);

  assign poll_byte  = stb_base | (STB_W'(rqs_reg)  << STB_RQS_BIT);
  assign query_byte = stb_base | (STB_W'(mss_wire) << STB_RQS_BIT);

  // poll beats query beats register read
  assign resp_next = serial_poll_in ? RESP_W'(poll_byte)
                   : stb_query_in   ? RESP_W'(query_byte)
                   : rd_value;

  // ==========================================================
  // service request and enable mask
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sre_reg      <= SRE_RST;
      rqs_reg      <= 1'b0;
      mss_prev_reg <= 1'b0;
    end else begin
      if (sre_wr_in) begin
        sre_reg <= sre_data_in;
      end
      rqs_reg      <= rqs_next;
      mss_prev_reg <= mss_wire;
    end
  end

  // ==========================================================
  // response register; data holds until the next answer
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      resp_valid_reg <= 1'b0;
      resp_data_reg  <= '0;
    end else begin
      resp_valid_reg <= serial_poll_in || stb_query_in || rd_take;
      if (serial_poll_in || stb_query_in || rd_take) begin
        resp_data_reg <= resp_next;
      end
    end
  end

  assign resp_valid_out = resp_valid_reg;
  assign resp_data_out  = resp_data_reg;
  assign srq_out        = rqs_reg;

  // ==========================================================
  // checks
  a_poll_clears_rqs: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (serial_poll_in && !mss_rise) |=> !srq_out ##1 (srq_out == $past(mss_rise)))
    else $error("poll did not withdraw service request");
  a_query_keeps_rqs: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (stb_query_in && !serial_poll_in && srq_out) |=> srq_out)
    else $error("status query disturbed service request");
  a_poll_bit_six: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    serial_poll_in |=> resp_valid_out && (resp_data_out[STB_RQS_BIT] == $past(srq_out)))
    else $error("poll bit 6 is not the request flag");
  a_query_bit_six: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (stb_query_in && !serial_poll_in) |=> resp_valid_out
    && (resp_data_out[STB_RQS_BIT] == $past(mss_wire)))
    else $error("query bit 6 is not master summary");
  a_query_sources: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (stb_query_in && !serial_poll_in) |=>
    (resp_data_out[STB_MAV_BIT] == $past(msg_avail_in))
    && (resp_data_out[STB_ESB_BIT] == $past(|(std_event_in & std_event_enable_in)))
    && (resp_data_out[RESP_W-1:STB_W] == '0))
    else $error("query byte does not match its sources");
  a_oper_summary: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (serial_poll_in || stb_query_in) |=>
    (resp_data_out[STB_OPER_BIT] == $past(|(op_if.event_bits & op_if.enable)))
    && (resp_data_out[STB_QUES_BIT] == $past(|(qs_if.event_bits & qs_if.enable))))
    else $error("group summary bit wrong in status byte");
  a_motor_event: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ($rose(motor_position_wait_in) && op_if.ptr[OP_MOTOR_BIT])
    |=> op_if.event_bits[OP_MOTOR_BIT])
    else $error("motor wait rise not latched at bit 1");
  a_rqs_on_rise: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    mss_rise |=> srq_out [*2] or (mss_rise ##1 serial_poll_in))
    else $error("service request not raised by new summary");

endmodule

// File: verif/isr_host_model.sv
`timescale 1ns/100ps
// ==========================================================
// bus controller stand-in: polls, status queries, register access
module isr_host_model
  import isr_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              resp_valid_in,
  input  wire logic [RESP_W-1:0] resp_data_in,
  output logic                   serial_poll_out,
  output logic                   stb_query_out,
  output logic                   reg_rd_out,
  output logic                   reg_wr_out,
  output logic                   reg_grp_out,
  output isr_item_e              reg_item_out,
  output logic      [RESP_W-1:0] reg_wdata_out,
  output logic                   sre_wr_out,
  output logic      [STB_W-1:0]  sre_data_out,
  output logic                   cls_out
);
  // idle bus at time zero, nothing requested
  initial begin
    {serial_poll_out, stb_query_out, reg_rd_out, reg_wr_out, sre_wr_out, cls_out} = 6'h00;
    reg_grp_out   = GRP_OP;
    reg_item_out  = ITEM_COND;
    reg_wdata_out = 16'h0000;
    sre_data_out  = 8'h00;
  end

  // kind: 0 poll, 1 query, 2 read, 3 write, 4 sre write, 5 clear
  // strobes are one-cycle pulses; answer wait is bounded so a dead block cannot hang us
  task automatic access(input int kind, input logic grp, input isr_item_e item,
                        input logic [RESP_W-1:0] wd, output logic [RESP_W-1:0] rd,
                        output bit ok);
    int n;
    @(negedge clk_in);
    reg_grp_out     = grp;
    reg_item_out    = item;
    reg_wdata_out   = wd;
    sre_data_out    = wd[STB_W-1:0];
    serial_poll_out = (kind == 0);
    stb_query_out   = (kind == 1);
    reg_rd_out      = (kind == 2);
    reg_wr_out      = (kind == 3);
    sre_wr_out      = (kind == 4);
    cls_out         = (kind == 5);
    @(negedge clk_in);
    {serial_poll_out, stb_query_out, reg_rd_out, reg_wr_out, sre_wr_out, cls_out} = 6'h00;
    n = 0;
    while (kind < 3 && resp_valid_in !== 1'b1 && n < 4) begin
      @(negedge clk_in);
      n++;
    end
    ok = (kind >= 3) || (resp_valid_in === 1'b1);
    rd = resp_data_in;
  endtask
endmodule

// File: verif/tb_top.sv
`timescale 1ns/100ps
// ==========================================================
// self-checking bench for the status reporting block
module tb_top;
  import isr_pkg::*;
  localparam int K_POLL  = 0;
  localparam int K_QUERY = 1;
  localparam int K_READ  = 2;
  localparam int K_WRITE = 3;
  localparam int K_SRE   = 4;
  localparam int K_CLS   = 5;
  logic              clk_in;
  logic              rst_n_in;
  logic [15:0]       op_drv;
  logic [15:0]       qs_drv;
  logic [ESR_W-1:0]  std_event;
  logic [ESR_W-1:0]  std_enable;
  logic              msg_avail;
  logic              serial_poll;
  logic              stb_query;
  logic              reg_rd;
  logic              reg_wr;
  logic              reg_grp;
  isr_item_e         reg_item;
  logic [RESP_W-1:0] reg_wdata;
  logic              sre_wr;
  logic [STB_W-1:0]  sre_data;
  logic              cls;
  logic              resp_valid;
  logic [RESP_W-1:0] resp_data;
  logic              srq;
  int                err_count;
  int                samples_checked;

  // ==========================================================
  // block under test and its controller
  isr_status_top i_isr_status_top (
    .clk_in(clk_in), .rst_n_in(rst_n_in),
    .motor_position_wait_in(op_drv[1]), .ranging_in(op_drv[2]), .measuring_in(op_drv[4]),
    .processing_in(op_drv[9]), .hardcopy_in(op_drv[10]), .averaging_in(op_drv[11]),
    .power_high_in(qs_drv[3]), .max_signals_in(qs_drv[9]), .drift_ref_mismatch_in(qs_drv[10]),
    .delta_ref_missing_in(qs_drv[11]), .cmd_warning_in(qs_drv[14]),
    .std_event_in(std_event), .std_event_enable_in(std_enable), .msg_avail_in(msg_avail),
    .serial_poll_in(serial_poll), .stb_query_in(stb_query), .sre_wr_in(sre_wr),
    .sre_data_in(sre_data), .cls_in(cls), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_grp_in(reg_grp), .reg_item_in(reg_item), .reg_wdata_in(reg_wdata),
    .resp_valid_out(resp_valid), .resp_data_out(resp_data), .srq_out(srq));
  isr_host_model i_isr_host_model (
    .clk_in(clk_in), .resp_valid_in(resp_valid), .resp_data_in(resp_data),
    .serial_poll_out(serial_poll), .stb_query_out(stb_query), .reg_rd_out(reg_rd),
    .reg_wr_out(reg_wr), .reg_grp_out(reg_grp), .reg_item_out(reg_item),
    .reg_wdata_out(reg_wdata), .sre_wr_out(sre_wr), .sre_data_out(sre_data), .cls_out(cls));

  // ==========================================================
  // shared helpers
  task automatic test_done();
    if (err_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("[ERR] %0t ns: got %h, expected %h", $time, got, exp);
      err_count++;
    end
  endtask

  // a missing answer ends the run at once
  task automatic xfer(input int kind, input logic grp, input isr_item_e item,
                      input logic [15:0] wd, output logic [15:0] rd);
    bit ok;
    i_isr_host_model.access(kind, grp, item, wd, rd, ok);
    if (!ok) begin
      $display("[ERR] %0t ns: no answer from block", $time);
      err_count++;
      test_done();
    end
  endtask

  task automatic expect_rd(input int kind, input logic grp, input isr_item_e item,
                           input logic [15:0] exp);
    logic [15:0] rd;
    xfer(kind, grp, item, 16'h0000, rd);
    check(rd, exp);
  endtask

  task automatic wr(input int kind, input logic grp, input isr_item_e item,
                    input logic [15:0] wd);
    logic [15:0] rd;
    xfer(kind, grp, item, wd, rd);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    for (int g = 0; g < 2; g++) begin
      expect_rd(K_READ, g[0], ITEM_ENABLE, 16'h0000);
      expect_rd(K_READ, g[0], ITEM_PTR, 16'hffff);
      expect_rd(K_READ, g[0], ITEM_NTR, 16'h0000);
      expect_rd(K_READ, g[0], ITEM_EVENT, 16'h0000);
    end
    expect_rd(K_QUERY, GRP_OP, ITEM_COND, 16'h0000);
    check({15'h0000, srq}, 16'h0000);
  endtask

  // one condition at a time: only its own position may show
  task automatic t_cond();
    int          pos [11] = '{1, 2, 4, 9, 10, 11, 3, 9, 10, 11, 14};
    logic [15:0] one;
    for (int i = 0; i < 11; i++) begin
      one = 16'h0001 << pos[i];
      @(negedge clk_in);
      op_drv = (i < 6) ? one : 16'h0000;
      qs_drv = (i < 6) ? 16'h0000 : one;
      expect_rd(K_READ, i >= 6, ITEM_COND, one);
    end
    @(negedge clk_in);
    op_drv = 16'h0000;
    qs_drv = 16'h0000;
    wr(K_CLS, GRP_OP, ITEM_COND, 16'h0000);
  endtask

  // rising filter, then falling filter on the measuring bit
  task automatic t_trans();
    wr(K_WRITE, GRP_OP, ITEM_PTR, 16'h0010);
    @(negedge clk_in);
    op_drv = 16'h0010;
    expect_rd(K_READ, GRP_OP, ITEM_EVENT, 16'h0010);
    expect_rd(K_READ, GRP_OP, ITEM_EVENT, 16'h0000);
    wr(K_WRITE, GRP_OP, ITEM_PTR, 16'h0000);
    wr(K_WRITE, GRP_OP, ITEM_NTR, 16'h0010);
    @(negedge clk_in);
    op_drv = 16'h0000;
    expect_rd(K_READ, GRP_OP, ITEM_EVENT, 16'h0010);
    @(negedge clk_in);
    op_drv = 16'h0010;
    expect_rd(K_READ, GRP_OP, ITEM_EVENT, 16'h0000);
    wr(K_WRITE, GRP_OP, ITEM_PTR, 16'hffff);
    wr(K_WRITE, GRP_OP, ITEM_NTR, 16'h0000);
    @(negedge clk_in);
    op_drv = 16'h0000;
    wr(K_CLS, GRP_OP, ITEM_COND, 16'h0000);
  endtask

  // build the status byte bit by bit, then poll against query
  task automatic t_summary();
    @(negedge clk_in);
    op_drv = 16'h0010;
    qs_drv = 16'h0008;
    expect_rd(K_QUERY, GRP_OP, ITEM_COND, 16'h0000);
    wr(K_WRITE, GRP_OP, ITEM_ENABLE, 16'h0010);
    expect_rd(K_QUERY, GRP_OP, ITEM_COND, 16'h0080);
    wr(K_WRITE, GRP_QS, ITEM_ENABLE, 16'h0008);
    expect_rd(K_QUERY, GRP_OP, ITEM_COND, 16'h0088);
    msg_avail = 1'b1;
    std_event = 8'h04;
    expect_rd(K_QUERY, GRP_OP, ITEM_COND, 16'h0098);
    std_enable = 8'h04;
    expect_rd(K_QUERY, GRP_OP, ITEM_COND, 16'h00b8);
    check({15'h0000, srq}, 16'h0000);
    wr(K_SRE, GRP_OP, ITEM_COND, 16'h0080);
    repeat (3) @(negedge clk_in);
    check({15'h0000, srq}, 16'h0001);
    expect_rd(K_QUERY, GRP_OP, ITEM_COND, 16'h00f8);
    check({15'h0000, srq}, 16'h0001);
    expect_rd(K_POLL, GRP_OP, ITEM_COND, 16'h00f8);
    check({15'h0000, srq}, 16'h0000);
    expect_rd(K_POLL, GRP_OP, ITEM_COND, 16'h00b8);
    msg_avail = 1'b0;
    expect_rd(K_QUERY, GRP_OP, ITEM_COND, 16'h00e8);
    std_event = 8'h00;
    expect_rd(K_QUERY, GRP_OP, ITEM_COND, 16'h00c8);
    expect_rd(K_READ, GRP_OP, ITEM_EVENT, 16'h0010);
    expect_rd(K_QUERY, GRP_OP, ITEM_COND, 16'h0008);
  endtask

  // ==========================================================
  // clock at 20 MHz
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  // main sequence: reset for 8 cycles, then each scenario in turn
  initial begin
    err_count       = 0;
    samples_checked = 0;
    rst_n_in        = 1'b0;
    op_drv          = 16'h0000;
    qs_drv          = 16'h0000;
    std_event       = 8'h00;
    std_enable      = 8'h00;
    msg_avail       = 1'b0;
    repeat (8) @(posedge clk_in);
    @(negedge clk_in);
    rst_n_in = 1'b1;
    t_reset();
    t_cond();
    t_trans();
    t_summary();
    test_done();
  end
endmodule
